//--- rtl/irq_regs_pkg.sv
// constants for the flag and priority register block
package irq_regs_pkg;
	// -----------------------------------------------------------------
	// register map (byte offset within a page, word index = offset / 4)
	// -----------------------------------------------------------------
	localparam logic [3:0]  ADDR_FLAG_STATUS_5   = 4'h0;
	localparam logic [3:0]  ADDR_FLAG_STATUS_6   = 4'h4;
	localparam logic [3:0]  ADDR_PRIORITY_CTRL_0 = 4'h8;
	localparam logic [3:0]  ADDR_IRQ_STATUS      = 4'hC;
	localparam logic [3:0]  ADDR_IRQ_CLEAR       = 4'h0;
	localparam logic [3:0]  ADDR_IRQ_ENABLE      = 4'h4;
	localparam logic [1:0]  PAGE_REGS            = 2'h0;
	localparam logic [1:0]  PAGE_IRQ             = 2'h1;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int          UART3_ERR_BIT        = 1;
	localparam int          GFX_BIT              = 4;
	localparam int          T1_LSB               = 12;
	localparam int          OC1_LSB              = 8;
	localparam int          IC1_LSB              = 4;
	localparam int          INT0_LSB             = 0;
	localparam int          PRIO_W               = 3;
	// -----------------------------------------------------------------
	// masks and reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] FS5_MASK             = 16'h0002;
	localparam logic [15:0] FS6_MASK             = 16'h0010;
	localparam logic [15:0] PRIO_MASK            = 16'h7777;
	localparam logic [15:0] PRIO_RESET           = 16'h4444;
	localparam logic [2:0]  PRIO_DISABLED        = 3'h0;
	localparam logic [3:0]  SRC_EN_RESET         = 4'hF;
	localparam logic [31:0] UNMAPPED_DATA        = 32'h00000000;
	localparam logic [1:0]  EVT_UART3_ERR        = 2'h0;
	localparam logic [1:0]  EVT_GFX              = 2'h1;
endpackage

//--- rtl/prio_if.sv
// priority field carrier between top and priority decode helper
`timescale 1ns/1ps
`default_nettype none
interface prio_if;
	logic [15:0] prio_word;
	logic [3:0]  src_enabled;
	modport ctrl (output prio_word, input src_enabled);
	modport dec  (input prio_word, output src_enabled);
endinterface
`default_nettype wire

//--- rtl/prio_decode.sv
// decodes priority fields into per-source enabled flags
`timescale 1ns/1ps
`default_nettype none
module prio_decode
	import irq_regs_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	prio_if.dec       pif
);
	// -----------------------------------------------------------------
	// field value 000 disables the source
	// -----------------------------------------------------------------
	function automatic logic field_on(input logic [15:0] w, input int lsb);
		field_on = (w[lsb +: PRIO_W] != PRIO_DISABLED);
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pif.src_enabled <= SRC_EN_RESET;
		end else begin
			pif.src_enabled <= {field_on(pif.prio_word, T1_LSB), field_on(pif.prio_word, OC1_LSB),
				field_on(pif.prio_word, IC1_LSB), field_on(pif.prio_word, INT0_LSB)};
		end
	end
endmodule
`default_nettype wire

//--- rtl/interrupt_flag_priority_regs.sv
// interrupt flag status 5/6 and priority control 0 register block
// Summary of operation
// - uart3 error flag at flag status 5 bit 1
// - flag status 5 bit 0 reads zero
// - flag status 6 other bits read zero
// - graphics flag bit 4, hardware set, reset 0
// - flag reads 1 after its request occurred
// - four 3-bit priority fields, reset 100
// - field 000 disables source, 111 highest
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_priority_regs
	import irq_regs_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        UART3_ERR_REQ,
	input  wire logic        GFX_REQ,
	output logic             UART3_ERR_FLAG,
	output logic             GFX_FLAG,
	output logic [2:0]       T1_PRIORITY,
	output logic [2:0]       OC1_PRIORITY,
	output logic [2:0]       IC1_PRIORITY,
	output logic [2:0]       INT0_PRIORITY,
	output logic [3:0]       SRC_ENABLED,
	output logic             IRQ
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic        uart3_err_r;
	logic        gfx_r;
	logic [2:0]  t1_prio_r;
	logic [2:0]  oc1_prio_r;
	logic [2:0]  ic1_prio_r;
	logic [2:0]  int0_prio_r;
	logic [15:0] prio_word;
	logic        uart3_sts_r;
	logic        gfx_sts_r;
	logic [1:0]  evt_en_r;
	logic        ack_r;
	logic [31:0] rdata_nxt;
	logic        wr_go;
	logic        rd_go;
	logic [1:0]  page;
	logic [3:0]  woff;
	logic        in_page;
	logic [15:0] wmask;
	logic        sel_fs5;
	logic        sel_fs6;
	logic        sel_prio;
	logic        sel_sts;
	logic        sel_clr;
	logic        sel_en;
	logic        uart3_evt;
	logic        gfx_evt;
	logic        uart3_err_req_r;
	logic        gfx_req_r;
	prio_if      pif ();

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic hit(input logic [1:0] p, input logic [3:0] o,
			input logic [1:0] wp, input logic [3:0] wo);
		hit = (p == wp) && (o == wo);
	endfunction

	// takes one priority field from write data when its byte lane is on
	function automatic logic [2:0] field_wr(input logic [2:0] cur, input logic [15:0] data,
			input logic [15:0] mask, input int lsb);
		field_wr = mask[lsb] ? data[lsb +: PRIO_W] : cur;
	endfunction

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	assign page     = AVS_ADDRESS[4:3];
	assign in_page  = !AVS_ADDRESS[2];
	assign woff     = {AVS_ADDRESS[1:0], 2'b00};
	assign sel_fs5  = in_page && hit(page, woff, PAGE_REGS, ADDR_FLAG_STATUS_5);
	assign sel_fs6  = in_page && hit(page, woff, PAGE_REGS, ADDR_FLAG_STATUS_6);
	assign sel_prio = in_page && hit(page, woff, PAGE_REGS, ADDR_PRIORITY_CTRL_0);
	assign sel_sts  = in_page && hit(page, woff, PAGE_REGS, ADDR_IRQ_STATUS);
	assign sel_clr  = in_page && hit(page, woff, PAGE_IRQ, ADDR_IRQ_CLEAR);
	assign sel_en   = in_page && hit(page, woff, PAGE_IRQ, ADDR_IRQ_ENABLE);
	assign wmask    = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	// writes land on the edge where waitrequest is seen low
	assign wr_go    = AVS_WRITE && !AVS_WAITREQUEST;
	assign rd_go    = AVS_READ && !ack_r;

	// -----------------------------------------------------------------
	// request edge capture, same clock domain
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			uart3_err_req_r <= 1'b0;
			gfx_req_r       <= 1'b0;
		end else begin
			uart3_err_req_r <= UART3_ERR_REQ;
			gfx_req_r       <= GFX_REQ;
		end
	end
	assign uart3_evt = UART3_ERR_REQ && !uart3_err_req_r;
	assign gfx_evt   = GFX_REQ && !gfx_req_r;

	// -----------------------------------------------------------------
	// bus handshake: one wait state per access
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_r);
		end
	end

	// -----------------------------------------------------------------
	// flag status 5: uart3 error flag
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			uart3_err_r <= 1'b0;
		end else if (uart3_evt) begin
			uart3_err_r <= 1'b1;
		end else if (wr_go && sel_fs5 && AVS_BYTEENABLE[0]) begin
			uart3_err_r <= AVS_WRITEDATA[UART3_ERR_BIT];
		end
	end

	// -----------------------------------------------------------------
	// flag status 6: graphics flag
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			gfx_r <= 1'b0;
		end else if (gfx_evt) begin
			gfx_r <= 1'b1;
		end else if (wr_go && sel_fs6 && AVS_BYTEENABLE[0]) begin
			gfx_r <= AVS_WRITEDATA[GFX_BIT];
		end
	end

	// -----------------------------------------------------------------
	// priority control 0: one register per field
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			t1_prio_r <= PRIO_RESET[T1_LSB +: PRIO_W];
		end else if (wr_go && sel_prio) begin
			t1_prio_r <= field_wr(t1_prio_r, AVS_WRITEDATA[15:0], wmask, T1_LSB);
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			oc1_prio_r <= PRIO_RESET[OC1_LSB +: PRIO_W];
		end else if (wr_go && sel_prio) begin
			oc1_prio_r <= field_wr(oc1_prio_r, AVS_WRITEDATA[15:0], wmask, OC1_LSB);
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			ic1_prio_r <= PRIO_RESET[IC1_LSB +: PRIO_W];
		end else if (wr_go && sel_prio) begin
			ic1_prio_r <= field_wr(ic1_prio_r, AVS_WRITEDATA[15:0], wmask, IC1_LSB);
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			int0_prio_r <= PRIO_RESET[INT0_LSB +: PRIO_W];
		end else if (wr_go && sel_prio) begin
			int0_prio_r <= field_wr(int0_prio_r, AVS_WRITEDATA[15:0], wmask, INT0_LSB);
		end
	end
	// spare bits 15, 11, 7 and 3 stay zero
	assign prio_word = {1'b0, t1_prio_r, 1'b0, oc1_prio_r, 1'b0, ic1_prio_r, 1'b0, int0_prio_r};

	// -----------------------------------------------------------------
	// interrupt status, set beats clear
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			uart3_sts_r <= 1'b0;
		end else if (uart3_evt) begin
			uart3_sts_r <= 1'b1;
		end else if (wr_go && sel_clr && AVS_WRITEDATA[EVT_UART3_ERR]) begin
			uart3_sts_r <= 1'b0;
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			gfx_sts_r <= 1'b0;
		end else if (gfx_evt) begin
			gfx_sts_r <= 1'b1;
		end else if (wr_go && sel_clr && AVS_WRITEDATA[EVT_GFX]) begin
			gfx_sts_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// interrupt enable
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			evt_en_r <= 2'h0;
		end else if (wr_go && sel_en && AVS_BYTEENABLE[0]) begin
			evt_en_r <= AVS_WRITEDATA[1:0];
		end
	end

	// -----------------------------------------------------------------
	// interrupt output
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |({gfx_sts_r, uart3_sts_r} & evt_en_r);
		end
	end

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	always_comb begin
		rdata_nxt = UNMAPPED_DATA;
		if (sel_fs5) begin
			rdata_nxt = {16'h0000, 14'h0000, uart3_err_r, 1'b0} & {16'h0000, FS5_MASK};
		end else if (sel_fs6) begin
			rdata_nxt = {16'h0000, 11'h000, gfx_r, 4'h0} & {16'h0000, FS6_MASK};
		end else if (sel_prio) begin
			rdata_nxt = {16'h0000, prio_word & PRIO_MASK};
		end else if (sel_sts) begin
			rdata_nxt = {30'h0, gfx_sts_r, uart3_sts_r};
		end else if (sel_en) begin
			rdata_nxt = {30'h0, evt_en_r};
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			AVS_READDATA <= UNMAPPED_DATA;
		end else if (rd_go) begin
			AVS_READDATA <= rdata_nxt;
		end
	end

	// -----------------------------------------------------------------
	// priority decode
	// -----------------------------------------------------------------
	assign pif.prio_word = prio_word;
	prio_decode u_dec (
		.clk (CORE_CLK),
		.rst (RESET),
		.pif (pif)
	);

	// -----------------------------------------------------------------
	// registered outputs
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			UART3_ERR_FLAG <= 1'b0;
			GFX_FLAG       <= 1'b0;
		end else begin
			UART3_ERR_FLAG <= uart3_err_r;
			GFX_FLAG       <= gfx_r;
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			T1_PRIORITY    <= PRIO_RESET[T1_LSB +: PRIO_W];
			OC1_PRIORITY   <= PRIO_RESET[OC1_LSB +: PRIO_W];
			IC1_PRIORITY   <= PRIO_RESET[IC1_LSB +: PRIO_W];
			INT0_PRIORITY  <= PRIO_RESET[INT0_LSB +: PRIO_W];
		end else begin
			T1_PRIORITY    <= t1_prio_r;
			OC1_PRIORITY   <= oc1_prio_r;
			IC1_PRIORITY   <= ic1_prio_r;
			INT0_PRIORITY  <= int0_prio_r;
		end
	end
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			SRC_ENABLED    <= SRC_EN_RESET;
		end else begin
			SRC_ENABLED    <= pif.src_enabled;
		end
	end
endmodule
`default_nettype wire

//--- sim/irq_regs_props.sv
// assertion checker for the flag and priority register block
`timescale 1ns/1ps
`default_nettype none
module irq_regs_props (
	input wire logic        CORE_CLK,
	input wire logic        RESET,
	input wire logic [4:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        UART3_ERR_REQ,
	input wire logic        GFX_REQ,
	input wire logic        UART3_ERR_FLAG,
	input wire logic        GFX_FLAG,
	input wire logic [2:0]  T1_PRIORITY,
	input wire logic [2:0]  OC1_PRIORITY,
	input wire logic [2:0]  IC1_PRIORITY,
	input wire logic [2:0]  INT0_PRIORITY,
	input wire logic [3:0]  SRC_ENABLED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	// ----------------------------------------
	// bus steps
	// ----------------------------------------
	sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
	sequence s_ack; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
	sequence s_rd(a); AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a; endsequence
	property p_wait; s_req |=> s_ack; endproperty
	property p_fs5; s_rd(5'h00) |-> (AVS_READDATA & 32'hFFFFFFFD) == 32'h0; endproperty
	property p_fs6; s_rd(5'h01) |-> (AVS_READDATA & 32'hFFFFFFEF) == 32'h0; endproperty
	property p_prio; s_rd(5'h02) |-> (AVS_READDATA & 32'hFFFF8888) == 32'h0; endproperty
	property p_src;
		SRC_ENABLED == {|$past(T1_PRIORITY), |$past(OC1_PRIORITY), |$past(IC1_PRIORITY), |$past(INT0_PRIORITY)};
	endproperty
	property p_gfx; $rose(GFX_REQ) |-> ##[1:3] GFX_FLAG; endproperty
	property p_uart; $rose(UART3_ERR_REQ) |-> ##[1:3] UART3_ERR_FLAG; endproperty
	property p_hold;
		$fell(GFX_FLAG) |-> $past(AVS_WRITE, 2) && !$past(AVS_WAITREQUEST, 2) && $past(AVS_ADDRESS, 2) == 5'h01;
	endproperty
	property p_uhold;
		$fell(UART3_ERR_FLAG) |-> $past(AVS_WRITE, 2) && !$past(AVS_WAITREQUEST, 2) && $past(AVS_ADDRESS, 2) == 5'h00;
	endproperty
	a_wait: assert property (p_wait) else $error("one wait state broken");
	a_fs5: assert property (p_fs5) else $error("status 5 spare bits set");
	a_fs6: assert property (p_fs6) else $error("status 6 spare bits set");
	a_prio: assert property (p_prio) else $error("priority spare bits set");
	a_src: assert property (p_src) else $error("source enable wrong");
	a_gfx: assert property (p_gfx) else $error("graphics flag not set");
	a_uart: assert property (p_uart) else $error("uart flag not set");
	a_hold: assert property (p_hold) else $error("flag dropped unasked");
	a_uhold: assert property (p_uhold) else $error("uart flag dropped unasked");
endmodule
bind interrupt_flag_priority_regs irq_regs_props u_irq_regs_props (.*);
`default_nettype wire

//--- sim/irq_source_model.sv
// request source model for the uart and graphics peripherals
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
	input  wire logic CORE_CLK,
	output var logic  UART3_ERR_REQ,
	output var logic  GFX_REQ
);
	initial begin
		UART3_ERR_REQ = 1'b0;
		GFX_REQ = 1'b0;
	end
	// level request for two cycles, its rise is the event
	task automatic pulse(input logic gfx);
		@(posedge CORE_CLK);
		if (gfx) GFX_REQ <= 1'b1;
		else UART3_ERR_REQ <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		GFX_REQ <= 1'b0;
		UART3_ERR_REQ <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the flag and priority register block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        CORE_CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
	logic        UART3_ERR_REQ, GFX_REQ, UART3_ERR_FLAG, GFX_FLAG;
	logic [4:0]  AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
	logic [3:0]  AVS_BYTEENABLE, SRC_ENABLED;
	logic [2:0]  T1_PRIORITY, OC1_PRIORITY, IC1_PRIORITY, INT0_PRIORITY;
	int          fail_count = 0;
	int          num_checks = 0;
	interrupt_flag_priority_regs u_interrupt_flag_priority_regs (.*);
	irq_source_model u_irq_source_model (.*);
	initial begin
		CORE_CLK = 1'b0;
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
		@(posedge CORE_CLK);
		AVS_READ <= !w;
		AVS_WRITE <= w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {16'h0000, d};
		AVS_BYTEENABLE <= be;
		@(posedge CORE_CLK);
		while (AVS_WAITREQUEST !== 1'b0) @(posedge CORE_CLK);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		acc(1'b1, a, d, 4'hF);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
		acc(1'b0, a, 16'h0000, 4'hF);
		chk(rd, exp);
	endtask
	task automatic fire(input logic gfx);
		u_irq_source_model.pulse(gfx);
		repeat (3) @(posedge CORE_CLK);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge CORE_CLK);
		fail_count++;
		report_and_stop();
	end
	initial begin
		RESET = 1'b1;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 5'h00;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hF;
		repeat (20) @(posedge CORE_CLK);
		RESET <= 1'b0;
		chk({28'h0, SRC_ENABLED}, 32'hF);
		rchk(5'h00, 32'h0);
		rchk(5'h01, 32'h0);
		rchk(5'h02, 32'h4444);
		wr(5'h00, 16'hFFFF);
		rchk(5'h00, 32'h2);
		wr(5'h01, 16'hFFFF);
		rchk(5'h01, 32'h10);
		wr(5'h00, 16'h0000);
		wr(5'h01, 16'h0000);
		fire(1'b0);
		rchk(5'h00, 32'h2);
		chk({31'h0, UART3_ERR_FLAG}, 32'h1);
		fire(1'b1);
		rchk(5'h01, 32'h10);
		chk({31'h0, GFX_FLAG}, 32'h1);
		wr(5'h00, 16'h0000);
		rchk(5'h00, 32'h0);
		wr(5'h01, 16'h0000);
		rchk(5'h01, 32'h0);
		for (int v = 0; v < 8; v++) begin
			wr(5'h02, 16'h8888 | (16'(v) * 16'h1111));
			rchk(5'h02, {16'h0000, 16'(v) * 16'h1111});
			repeat (3) @(posedge CORE_CLK);
			chk({29'h0, T1_PRIORITY}, 32'(v));
			chk({29'h0, OC1_PRIORITY}, 32'(v));
			chk({29'h0, IC1_PRIORITY}, 32'(v));
			chk({29'h0, INT0_PRIORITY}, 32'(v));
			chk({28'h0, SRC_ENABLED}, (v == 0) ? 32'h0 : 32'hF);
		end
		acc(1'b1, 5'h02, 16'h0010, 4'h1);
		rchk(5'h02, 32'h7710);
		repeat (3) @(posedge CORE_CLK);
		chk({29'h0, IC1_PRIORITY}, 32'h1);
		chk({29'h0, INT0_PRIORITY}, 32'h0);
		chk({28'h0, SRC_ENABLED}, 32'hE);
		wr(5'h10, 16'hFFFF);
		rchk(5'h10, 32'h0);
		wr(5'h08, 16'h0003);
		wr(5'h09, 16'h0001);
		repeat (2) @(posedge CORE_CLK);
		chk({31'h0, IRQ}, 32'h0);
		fire(1'b0);
		chk({31'h0, IRQ}, 32'h1);
		fire(1'b1);
		rchk(5'h03, 32'h3);
		wr(5'h08, 16'h0001);
		repeat (2) @(posedge CORE_CLK);
		chk({31'h0, IRQ}, 32'h0);
		wr(5'h09, 16'h0002);
		repeat (2) @(posedge CORE_CLK);
		chk({31'h0, IRQ}, 32'h1);
		wr(5'h08, 16'h0002);
		repeat (2) @(posedge CORE_CLK);
		chk({31'h0, IRQ}, 32'h0);
		rchk(5'h03, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
